// ==== core/bcbn_pkg.sv ====
// Behaviour
// - Bit-clear zeroes selected bit of addressed register
// - Access bit zero selects fixed access bank, except the indexed case below
// - Access bit one uses bank select pointer
// - Extended set, access zero, f<=5Fh indexed
// - Bit-clear: one cycle, decode/read/modify/write quarters
// - Branch adds twice signed offset to PC
// - Branch taken only when negative flag set
package bcbn_pkg;

  // ----------------------------------------
  // Encodings
  // ----------------------------------------
  localparam logic [3:0] BIT_CLEAR_OPC     = 4'h9;
  localparam logic [7:0] BRANCH_NEG_OPC    = 8'he6;
  localparam logic [7:0] INDEXED_LIMIT     = 8'h5f;
  localparam logic [7:0] ACCESS_SPLIT      = 8'h60;
  localparam logic [3:0] ACCESS_HIGH_BANK  = 4'hf;

  // ----------------------------------------
  // Reset values and PC step
  // ----------------------------------------
  localparam logic [1:0]  QUARTER_RESET    = 2'h0;
  localparam logic [20:0] PC_RESET         = 21'h00_0000;
  localparam logic [20:0] PC_STEP          = 21'h00_0002;

  typedef enum logic [1:0] {
    BCBN_Q1,
    BCBN_Q2,
    BCBN_Q3,
    BCBN_Q4
  } bcbn_quarter_type;

endpackage : bcbn_pkg

// ==== core/bcbn_quarter_gen.sv ====
`timescale 1ns/1ps
module bcbn_quarter_gen (
  input  wire logic                       core_clk,
  input  wire logic                       rst,
  input  wire logic                       clk_en,
  output bcbn_pkg::bcbn_quarter_type      quarter
);
  import bcbn_pkg::*;

  bcbn_quarter_type next_quarter;

  always_comb begin
    unique case (quarter)
      BCBN_Q1: next_quarter = BCBN_Q2;
      BCBN_Q2: next_quarter = BCBN_Q3;
      BCBN_Q3: next_quarter = BCBN_Q4;
      BCBN_Q4: next_quarter = BCBN_Q1;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      quarter <= BCBN_Q1;
    end else if (clk_en) begin
      quarter <= next_quarter;
    end
  end

endmodule : bcbn_quarter_gen

// ==== core/bcbn_core.sv ====
`timescale 1ns/1ps
module bcbn_core (
  input  wire logic          core_clk,
  input  wire logic          rst,
  input  wire logic          clk_en,
  input  wire logic [15:0]   instr_word,
  input  wire logic          instr_valid,
  input  wire logic [3:0]    bank_select_pointer,
  input  wire logic          extended_set_en,
  input  wire logic [7:0]    index_base,
  input  wire logic          negative_flag,
  input  wire logic [7:0]    reg_rdata,
  output logic      [11:0]   reg_addr,
  output logic               reg_rd,
  output logic               reg_wr,
  output logic      [7:0]    reg_wdata,
  output logic      [20:0]   pc,
  output logic               pc_wr,
  output logic               instr_taken,
  output logic               bubble
);
  import bcbn_pkg::*;

  // ----------------------------------------
  // Quarter sequencing
  // ----------------------------------------
  bcbn_quarter_type quarter;

  bcbn_quarter_gen u_quarter (
    .core_clk (core_clk),
    .rst      (rst),
    .clk_en   (clk_en),
    .quarter  (quarter)
  );

  // ----------------------------------------
  // Decode state
  // ----------------------------------------
  logic [15:0] op;
  logic        op_clear;
  logic        op_branch;
  logic        idle_cycle;
  logic [7:0]  data;
  logic [15:0] next_op;
  logic        next_op_clear;
  logic        next_op_branch;
  logic        next_idle_cycle;
  logic [7:0]  next_data;

  logic [11:0] next_reg_addr;
  logic        next_reg_rd;
  logic        next_reg_wr;
  logic [7:0]  next_reg_wdata;
  logic [20:0] next_pc;
  logic        next_pc_wr;
  logic        next_instr_taken;
  logic        next_bubble;

  logic [7:0]  f_field;
  logic [2:0]  bit_sel;
  logic        acc_bit;
  logic [11:0] oper_addr;
  logic [20:0] offset_x2;

  always_comb begin
    f_field   = op[7:0];
    bit_sel   = op[11:9];
    acc_bit   = op[8];
    offset_x2 = {{12{op[7]}}, op[7:0], 1'b0};
    if (acc_bit) begin
      oper_addr = {bank_select_pointer, f_field};
    end else if (extended_set_en && (f_field <= INDEXED_LIMIT)) begin
      oper_addr = {4'h0, 8'(index_base + f_field)};
    end else if (f_field < ACCESS_SPLIT) begin
      oper_addr = {4'h0, f_field};
    end else begin
      oper_addr = {ACCESS_HIGH_BANK, f_field};
    end
  end

  logic        branch_go;

  // Branch decision at the write quarter
  assign branch_go = op_branch && negative_flag;

  // ----------------------------------------
  // Decode group
  // ----------------------------------------
  always_comb begin
    next_op          = op;
    next_op_clear    = op_clear;
    next_op_branch   = op_branch;
    next_idle_cycle  = idle_cycle;
    next_instr_taken = 1'b0;
    next_bubble      = bubble;
    unique case (quarter)
      BCBN_Q1: begin
        // Decode, unless this is the idle cycle
        next_bubble = idle_cycle;
        if (idle_cycle) begin
          next_idle_cycle = 1'b0;
          next_op_clear   = 1'b0;
          next_op_branch  = 1'b0;
        end else begin
          next_op          = instr_word;
          next_op_clear    = instr_valid && (instr_word[15:12] == BIT_CLEAR_OPC);
          next_op_branch   = instr_valid && (instr_word[15:8] == BRANCH_NEG_OPC);
          next_instr_taken = instr_valid;
        end
      end
      BCBN_Q2, BCBN_Q3: begin
        // Decoded operation held
      end
      BCBN_Q4: begin
        if (branch_go) begin
          next_idle_cycle = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      op          <= 16'h0000;
      op_clear    <= 1'b0;
      op_branch   <= 1'b0;
      idle_cycle  <= 1'b0;
      instr_taken <= 1'b0;
      bubble      <= 1'b0;
    end else if (clk_en) begin
      op          <= next_op;
      op_clear    <= next_op_clear;
      op_branch   <= next_op_branch;
      idle_cycle  <= next_idle_cycle;
      instr_taken <= next_instr_taken;
      bubble      <= next_bubble;
    end
  end

  // ----------------------------------------
  // Register port group
  // ----------------------------------------
  always_comb begin
    next_data      = data;
    next_reg_addr  = reg_addr;
    next_reg_rd    = 1'b0;
    next_reg_wr    = 1'b0;
    next_reg_wdata = reg_wdata;
    unique case (quarter)
      BCBN_Q1: begin
        // Write-back pulse of the previous cycle ends
      end
      BCBN_Q2: begin
        if (op_clear) begin
          next_reg_addr = oper_addr;
          next_reg_rd   = 1'b1;
        end
      end
      BCBN_Q3: begin
        if (op_clear) begin
          next_data = reg_rdata & ~(8'h01 << bit_sel);
        end
      end
      BCBN_Q4: begin
        if (op_clear) begin
          next_reg_wr    = 1'b1;
          next_reg_wdata = data;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      data      <= 8'h00;
      reg_addr  <= 12'h000;
      reg_rd    <= 1'b0;
      reg_wr    <= 1'b0;
      reg_wdata <= 8'h00;
    end else if (clk_en) begin
      data      <= next_data;
      reg_addr  <= next_reg_addr;
      reg_rd    <= next_reg_rd;
      reg_wr    <= next_reg_wr;
      reg_wdata <= next_reg_wdata;
    end
  end

  // ----------------------------------------
  // Program counter group
  // ----------------------------------------
  always_comb begin
    next_pc    = pc;
    next_pc_wr = 1'b0;
    unique case (quarter)
      BCBN_Q1, BCBN_Q3: begin
        // PC holds while decoding and processing
      end
      BCBN_Q2: begin
        // Fetch increment, skipped in the idle cycle
        if (!bubble) begin
          next_pc = pc + PC_STEP;
        end
      end
      BCBN_Q4: begin
        if (branch_go) begin
          next_pc    = pc + offset_x2;
          next_pc_wr = 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (rst) begin
      pc    <= PC_RESET;
      pc_wr <= 1'b0;
    end else if (clk_en) begin
      pc    <= next_pc;
      pc_wr <= next_pc_wr;
    end
  end

endmodule : bcbn_core

// ==== test/bcbn_core_assertions.sv ====
`timescale 1ns/1ps
module bcbn_core_assertions
  import bcbn_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic [15:0] instr_word,
  input wire logic [3:0]  bank_select_pointer,
  input wire logic        extended_set_en,
  input wire logic [7:0]  index_base,
  input wire logic        negative_flag,
  input wire logic [7:0]  reg_rdata,
  input wire logic [11:0] reg_addr,
  input wire logic        reg_rd,
  input wire logic        reg_wr,
  input wire logic [7:0]  reg_wdata,
  input wire logic [20:0] pc,
  input wire logic        pc_wr,
  input wire logic        instr_taken,
  input wire logic        bubble
);
  // ----------------
  // Checks
  // ----------------
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  property p_clr;
    reg_wr |-> reg_wdata == ($past(reg_rdata, 2) & ~(8'h01 << $past(instr_word[11:9], 4)));
  endproperty
  a_clr: assert property (p_clr) else $error("clear value");
  property p_acc;
    reg_rd && !$past(instr_word[8], 2) && !(extended_set_en && $past(instr_word[7:0], 2)
    <= INDEXED_LIMIT) |-> reg_addr[7:0] == $past(instr_word[7:0], 2) && reg_addr[11:8]
    == (reg_addr[7:0] < ACCESS_SPLIT ? 4'h0 : ACCESS_HIGH_BANK);
  endproperty
  a_acc: assert property (p_acc) else $error("access bank");
  property p_bank;
    reg_rd && $past(instr_word[8], 2) |->
      reg_addr == {bank_select_pointer, $past(instr_word[7:0], 2)};
  endproperty
  a_bank: assert property (p_bank) else $error("bank pointer");
  property p_idx;
    reg_rd && !$past(instr_word[8], 2) && extended_set_en && $past(instr_word[7:0], 2)
    <= INDEXED_LIMIT |-> reg_addr == {4'h0, 8'(index_base + $past(instr_word[7:0], 2))};
  endproperty
  a_idx: assert property (p_idx) else $error("indexed");
  property p_seq;
    instr_taken && $past(instr_word[15:12]) == BIT_CLEAR_OPC |-> ##1 reg_rd ##2 reg_wr;
  endproperty
  a_seq: assert property (p_seq) else $error("clear quarters");
  property p_tgt;
    pc_wr |-> pc == $past(pc, 3) + PC_STEP
      + {{12{$past(instr_word[7], 4)}}, $past(instr_word[7:0], 4), 1'b0};
  endproperty
  a_tgt: assert property (p_tgt) else $error("target");
  property p_neg;
    instr_taken && $past(instr_word[15:8]) == BRANCH_NEG_OPC |->
      ##3 pc_wr == $past(negative_flag);
  endproperty
  a_neg: assert property (p_neg) else $error("branch decision");
  property p_idle;
    pc_wr |=> (bubble && !instr_taken) [*4];
  endproperty
  a_idle: assert property (p_idle) else $error("idle cycle");
endmodule : bcbn_core_assertions
bind bcbn_core bcbn_core_assertions bcbn_core_assertions_inst (.*);

// ==== test/bcbn_core_test.sv ====
`timescale 1ns/1ps
module bcbn_core_test;
  import bcbn_pkg::*;
  logic        core_clk = '0, rst = '1, clk_en = '1, instr_valid = '0;
  logic        extended_set_en = '0, negative_flag = '0;
  logic [15:0] instr_word = '0;
  logic [3:0]  bank_select_pointer = '0;
  logic [7:0]  index_base = '0, reg_rdata = '0, reg_wdata;
  logic [11:0] reg_addr;
  logic        reg_rd, reg_wr, pc_wr, instr_taken, bubble;
  logic [20:0] pc;
  int          mismatches = 0, compares = 0, pcm = 0;
  bcbn_core bcbn_core_inst (.*);
  initial forever #2.5 core_clk = ~core_clk;
  task chk(input logic [20:0] seen, exp, input string what);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  // ----------------
  // One instruction, then a gap or idle cycle
  // ----------------
  task run_op;
    logic [15:0] w;
    logic [11:0] ea;
    logic        v, bc, tk;
    int          k, t;
    k = $urandom % 3;
    w = 16'($urandom);
    if (k == 0) w[15:12] = BIT_CLEAR_OPC;
    else if (k == 1) w[15:8] = BRANCH_NEG_OPC;
    else w[15:12] = 4'h0;
    v = ($urandom % 8) != 0;
    instr_word <= w;
    instr_valid <= v;
    reg_rdata <= 8'($urandom);
    bank_select_pointer <= 4'($urandom);
    extended_set_en <= 1'($urandom);
    index_base <= 8'($urandom);
    negative_flag <= 1'($urandom);
    @(posedge core_clk);
    bc = v && k == 0;
    tk = v && k == 1 && negative_flag;
    instr_valid <= tk;
    if (w[8]) ea = {bank_select_pointer, w[7:0]};
    else if (extended_set_en && w[7:0] <= 8'h5f) ea = {4'h0, 8'(index_base + w[7:0])};
    else ea = {w[7:0] < 8'h60 ? 4'h0 : 4'hf, w[7:0]};
    @(posedge core_clk);
    chk(21'(instr_taken), 21'(v), "taken");
    @(posedge core_clk);
    chk(21'(reg_rd), 21'(bc), "rd");
    if (bc) chk(21'(reg_addr), 21'(ea), "addr");
    chk(pc, 21'(pcm + 2), "pc step");
    repeat (2) @(posedge core_clk);
    chk(21'(reg_wr), 21'(bc), "wr");
    if (bc) chk(21'(reg_wdata), 21'(reg_rdata & ~(8'h01 << w[11:9])), "wdata");
    chk(21'(pc_wr), 21'(tk), "pc_wr");
    t = tk ? pcm + 2 + 2 * $signed(w[7:0]) : pcm + 2;
    chk(pc, 21'(t), "pc");
    pcm = tk ? t : t + 2;
    @(posedge core_clk);
    chk(21'(bubble), 21'(tk), "bubble");
    chk(21'(instr_taken), 21'(0), "idle take");
    repeat (2) @(posedge core_clk);
  endtask : run_op
  // ----------------
  // Clock enable low freezes all state
  // ----------------
  task stall;
    int n;
    n = 3 + $urandom % 3;
    clk_en <= '0;
    instr_valid <= '1;
    repeat (n) @(posedge core_clk);
    chk(pc, 21'(pcm), "frozen pc");
    chk(21'(instr_taken), 21'(0), "frozen take");
    chk(21'(reg_rd), 21'(0), "frozen rd");
    clk_en <= '1;
  endtask : stall
  task test_done;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : test_done
  initial begin
    void'($urandom(32'h97e4));
    repeat (3) @(posedge core_clk);
    rst <= '0;
    repeat (300) begin
      run_op();
      if ($urandom % 4 == 0) stall();
    end
    test_done();
  end
endmodule : bcbn_core_test
